// ### include/aux_cmd_pkg.sv
package aux_cmd_pkg;

	////////////////////////////////////////////////////////////////////////////
	// command port placement and field layout
	localparam logic [8:0] CMD_PORT_OFFSET = 9'h11b;
	localparam int CTRL_MSB = 7;
	localparam int CTRL_LSB = 5;
	localparam int DATA_MSB = 4;
	localparam int DATA_LSB = 0;

	////////////////////////////////////////////////////////////////////////////
	// control codes: execute, or select a hidden register
	localparam logic [2:0] CTRL_EXEC = 3'h0;
	localparam logic [2:0] SEL_COUNTER = 3'h1;
	localparam logic [2:0] SEL_PP_CONFIG = 3'h3;
	localparam logic [2:0] SEL_CONFIG_A = 3'h4;
	localparam logic [2:0] SEL_CONFIG_B = 3'h5;
	localparam logic [2:0] SEL_CONFIG_E = 3'h6;

	////////////////////////////////////////////////////////////////////////////
	// immediate command codes
	localparam logic [4:0] CMD_PON = 5'h00;
	localparam logic [4:0] CMD_PP_CLEAR = 5'h01;
	localparam logic [4:0] CMD_CHIP_RESET = 5'h02;
	localparam logic [4:0] CMD_FINISH_HS = 5'h03;
	localparam logic [4:0] CMD_TRIGGER = 5'h04;
	localparam logic [4:0] CMD_RETURN_LOCAL = 5'h05;
	localparam logic [4:0] CMD_SEND_EOI = 5'h06;
	localparam logic [4:0] CMD_NON_VALID = 5'h07;
	localparam logic [4:0] CMD_PP_SET = 5'h09;
	localparam logic [4:0] CMD_VALID = 5'h0f;
	localparam logic [4:0] CMD_GO_STANDBY = 5'h10;
	localparam logic [4:0] CMD_TAKE_ASYNC = 5'h11;
	localparam logic [4:0] CMD_TAKE_SYNC = 5'h12;
	localparam logic [4:0] CMD_LISTEN = 5'h13;
	localparam logic [4:0] CMD_SC_DISABLE = 5'h14;
	localparam logic [4:0] CMD_IFC_CLEAR = 5'h16;
	localparam logic [4:0] CMD_REN_CLEAR = 5'h17;
	localparam logic [4:0] CMD_TAKE_SYNC_END = 5'h1a;
	localparam logic [4:0] CMD_LISTEN_CONT = 5'h1b;
	localparam logic [4:0] CMD_LOCAL_UNLISTEN = 5'h1c;
	localparam logic [4:0] CMD_EXEC_PP = 5'h1d;
	localparam logic [4:0] CMD_IFC_SET = 5'h1e;
	localparam logic [4:0] CMD_REN_SET = 5'h1f;

	localparam logic [31:0] ONE = 32'h0000_0001;
	localparam logic [31:0] IMPL_MASK =
		(ONE << CMD_PON) | (ONE << CMD_PP_CLEAR) | (ONE << CMD_CHIP_RESET) | (ONE << CMD_FINISH_HS) |
		(ONE << CMD_TRIGGER) | (ONE << CMD_RETURN_LOCAL) | (ONE << CMD_SEND_EOI) | (ONE << CMD_NON_VALID) |
		(ONE << CMD_PP_SET) | (ONE << CMD_VALID) | (ONE << CMD_GO_STANDBY) | (ONE << CMD_TAKE_ASYNC) |
		(ONE << CMD_TAKE_SYNC) | (ONE << CMD_LISTEN) | (ONE << CMD_SC_DISABLE) | (ONE << CMD_IFC_CLEAR) |
		(ONE << CMD_REN_CLEAR) | (ONE << CMD_TAKE_SYNC_END) | (ONE << CMD_LISTEN_CONT) |
		(ONE << CMD_LOCAL_UNLISTEN) | (ONE << CMD_EXEC_PP) | (ONE << CMD_IFC_SET) | (ONE << CMD_REN_SET);

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [4:0] CONFIG_RST = 5'h00;
	localparam logic [4:0] COUNTER_RST = 5'h08;

endpackage

// ### rtl/aux_cmd_onehot.sv
module aux_cmd_onehot (
	input wire logic [4:0] code, // command field
	output logic [31:0] onehot, // one bit per implemented command
	output logic known // code is an implemented command
);
	import aux_cmd_pkg::*;

	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_bit
			assign onehot[i] = (code == 5'(i)) && IMPL_MASK[i]; // [RL17]
		end
	endgenerate

	assign known = |onehot;

endmodule // aux_cmd_onehot

// ### rtl/aux_command_decoder.sv
// Overview of operation
// [RL1] write-only byte port: control bits, command bits
// [RL2] control zero executes selected special function
// [RL3] nonzero control loads selected hidden register
// [RL4] port is sole write path, five registers
// [RL5] 00 pon, 02 chip reset, 03 finish
// [RL6] 04 trigger, 05 local, 06 send EOI
// [RL7] 07 non-valid, 0F valid, release handshake
// [RL8] 01 clears, 09 sets parallel poll flag
// [RL9] 11, 12, 1A take control variants
// [RL10] 10 standby, 1D poll, 14 drop system-control
// [RL11] 13 listen, 1B continuous, 1C local unlisten
// [RL12] 1E asserts IFC, 16 releases it
// [RL13] 1F asserts REN, 17 releases it
// [RL14] read at port returns pass-through byte
// [RL15] chip reset clears A,B,E; counter eight
// [RL16] functions idle after reset until pon
// [RL17] unimplemented command codes change nothing
// [RL18] accepted command gives one-cycle pulse
module aux_command_decoder (
	input wire logic mclk, // 200 MHz clock
	input wire logic sys_rst, // sync reset, high
	input wire logic [8:0] reg_addr, // register offset
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_wdata, // write byte
	input wire logic [7:0] cpt_data, // pass-through byte from bus logic
	output logic [7:0] reg_rdata, // read byte, one cycle later
	output logic [31:0] cmd_pulse, // command pulses by code
	output logic [4:0] aux_config_a, // hidden register a
	output logic [4:0] aux_config_b, // hidden register b
	output logic [4:0] aux_config_e, // hidden register e
	output logic [4:0] parallel_poll_config, // parallel poll register
	output logic [4:0] internal_counter_config, // clock counter register
	output logic local_pp_flag, // local parallel poll flag
	output logic ifc_assert, // drive interface clear
	output logic ren_assert, // drive remote enable
	output logic idle_hold, // functions held idle
	output logic transceiver_mode_clear // pulse: clear both mode bits
);
	import aux_cmd_pkg::*;

	typedef struct packed {
		logic [7:0] rdata;
		logic [31:0] pulse;
		logic [4:0] cfg_a;
		logic [4:0] cfg_b;
		logic [4:0] cfg_e;
		logic [4:0] ppc;
		logic [4:0] counter;
		logic pp_flag;
		logic ifc;
		logic ren;
		logic hold;
		logic trm_clr;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic wr_hit;
	logic rd_hit;
	logic [2:0] ctrl;
	logic [4:0] data;
	logic [31:0] dec_onehot;
	logic dec_known;

	////////////////////////////////////////////////////////////////////////////
	// port decode
	assign wr_hit = reg_wr && (reg_addr == CMD_PORT_OFFSET); // [RL1]
	assign rd_hit = reg_rd && (reg_addr == CMD_PORT_OFFSET); // [RL14]
	assign ctrl = reg_wdata[CTRL_MSB:CTRL_LSB]; // [RL1]
	assign data = reg_wdata[DATA_MSB:DATA_LSB]; // [RL1]

	aux_cmd_onehot u_onehot (
		.code(data),
		.onehot(dec_onehot),
		.known(dec_known)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pulse = '0;
		nxt_st.rdata = '0;
		nxt_st.trm_clr = 1'b0;
		if (rd_hit) begin
			nxt_st.rdata = cpt_data; // [RL14]
		end
		if (wr_hit && (ctrl == CTRL_EXEC) && dec_known) begin
			// one pulse per command, pon through take-control and listen [RL5] [RL6] [RL7] [RL9] [RL10] [RL11]
			nxt_st.pulse = dec_onehot; // [RL2] [RL18]
			case (data)
				CMD_PON: begin
					nxt_st.hold = 1'b0; // [RL16]
				end
				CMD_CHIP_RESET: begin
					nxt_st.cfg_a = CONFIG_RST; // [RL15]
					nxt_st.cfg_b = CONFIG_RST; // [RL15]
					nxt_st.cfg_e = CONFIG_RST; // [RL15]
					nxt_st.counter = COUNTER_RST; // [RL15]
					nxt_st.trm_clr = 1'b1; // [RL15]
					nxt_st.pp_flag = 1'b0;
					nxt_st.ifc = 1'b0;
					nxt_st.ren = 1'b0;
					nxt_st.hold = 1'b1; // [RL16]
				end
				CMD_PP_CLEAR: begin
					nxt_st.pp_flag = 1'b0; // [RL8]
				end
				CMD_PP_SET: begin
					nxt_st.pp_flag = 1'b1; // [RL8]
				end
				CMD_IFC_SET: begin
					nxt_st.ifc = 1'b1; // [RL12]
				end
				CMD_IFC_CLEAR: begin
					nxt_st.ifc = 1'b0; // [RL12]
				end
				CMD_REN_SET: begin
					nxt_st.ren = 1'b1; // [RL13]
				end
				CMD_REN_CLEAR: begin
					nxt_st.ren = 1'b0; // [RL13]
				end
				default: begin
				end
			endcase
		end else if (wr_hit) begin
			// hidden registers loaded only from here; chip reset above also clears a, b, e and sets counter to eight [RL4]
			case (ctrl)
				SEL_CONFIG_A: nxt_st.cfg_a = data; // [RL3]
				SEL_CONFIG_B: nxt_st.cfg_b = data; // [RL3]
				SEL_CONFIG_E: nxt_st.cfg_e = data; // [RL3]
				SEL_PP_CONFIG: nxt_st.ppc = data; // [RL3]
				SEL_COUNTER: nxt_st.counter = data; // [RL3]
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.counter <= COUNTER_RST; // [RL15]
			st_ff.hold <= 1'b1; // [RL16]
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign cmd_pulse = st_ff.pulse;
	assign aux_config_a = st_ff.cfg_a;
	assign aux_config_b = st_ff.cfg_b;
	assign aux_config_e = st_ff.cfg_e;
	assign parallel_poll_config = st_ff.ppc;
	assign internal_counter_config = st_ff.counter;
	assign local_pp_flag = st_ff.pp_flag;
	assign ifc_assert = st_ff.ifc;
	assign ren_assert = st_ff.ren;
	assign idle_hold = st_ff.hold;
	assign transceiver_mode_clear = st_ff.trm_clr;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_exec_write;
		wr_hit && (ctrl == CTRL_EXEC);
	endsequence

	sequence s_load_write;
		wr_hit && (ctrl != CTRL_EXEC);
	endsequence

	sequence s_cmd_write(logic [4:0] c);
		wr_hit && (ctrl == CTRL_EXEC) && (data == c);
	endsequence

	sequence s_chip_reset_then_quiet;
		s_cmd_write(CMD_CHIP_RESET) ##1 (!(wr_hit && (ctrl == CTRL_EXEC) && (data == CMD_PON)))[*3];
	endsequence

	a_exec_pulse_one: assert property ( // [RL2] [RL18]
		s_exec_write and (IMPL_MASK[data] == 1'b1)
		|=> (cmd_pulse == (ONE << $past(data))) ##1 (cmd_pulse == '0 || $past(wr_hit)))
		else $error("command write did not give a single one-cycle pulse");

	a_pulse_onehot: assert property ( // [RL18]
		$onehot0(cmd_pulse))
		else $error("more than one command pulse at once");

	a_load_no_pulse: assert property ( // [RL3]
		s_load_write |=> (cmd_pulse == '0))
		else $error("register load produced a command pulse");

	a_load_cfg_a: assert property ( // [RL3] [RL4]
		wr_hit && (ctrl == SEL_CONFIG_A) |=> (aux_config_a == $past(data)))
		else $error("hidden register a not loaded");

	a_load_counter: assert property ( // [RL3] [RL4]
		wr_hit && (ctrl == SEL_COUNTER) |=> (internal_counter_config == $past(data)))
		else $error("counter register not loaded");

	a_hidden_only_port: assert property ( // [RL4]
		!wr_hit |=> $stable(aux_config_a) && $stable(aux_config_b) && $stable(aux_config_e)
			&& $stable(parallel_poll_config) && $stable(internal_counter_config))
		else $error("hidden register changed without a port write");

	a_unknown_ignored: assert property ( // [RL17]
		s_exec_write and (IMPL_MASK[data] == 1'b0)
		|=> (cmd_pulse == '0) && $stable(local_pp_flag) && $stable(ifc_assert)
			&& $stable(ren_assert) && $stable(idle_hold) && $stable(aux_config_a))
		else $error("unimplemented command changed state");

	a_chip_reset_vals: assert property ( // [RL15]
		s_cmd_write(CMD_CHIP_RESET) |=> (internal_counter_config == COUNTER_RST)
			&& (aux_config_a == CONFIG_RST) && (aux_config_b == CONFIG_RST)
			&& (aux_config_e == CONFIG_RST) && transceiver_mode_clear && idle_hold)
		else $error("chip reset left wrong register values");

	a_hold_until_pon: assert property ( // [RL16]
		s_chip_reset_then_quiet |-> idle_hold)
		else $error("idle hold dropped without pon");

	a_pon_release: assert property ( // [RL16]
		s_cmd_write(CMD_PON) |=> !idle_hold)
		else $error("pon did not release idle hold");

	a_pp_flag_set: assert property ( // [RL8]
		s_cmd_write(CMD_PP_SET) |=> local_pp_flag ##1 (local_pp_flag || $past(wr_hit)))
		else $error("parallel poll flag not set");

	a_pp_flag_clear: assert property ( // [RL8]
		s_cmd_write(CMD_PP_CLEAR) |=> !local_pp_flag)
		else $error("parallel poll flag not cleared");

	a_ifc_control: assert property ( // [RL12]
		s_cmd_write(CMD_IFC_SET) |=> ifc_assert ##1 (ifc_assert || $past(wr_hit)))
		else $error("interface clear not held");

	a_ren_control: assert property ( // [RL13]
		s_cmd_write(CMD_REN_CLEAR) |=> !ren_assert)
		else $error("remote enable not released");

	a_read_passthru: assert property ( // [RL14]
		rd_hit |=> (reg_rdata == $past(cpt_data)))
		else $error("read did not return pass-through byte");

endmodule // aux_command_decoder

// ### tb/aux_command_decoder_tb.sv
module aux_command_decoder_tb import aux_cmd_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [8:0] reg_addr;
	logic reg_wr, reg_rd;
	logic [7:0] reg_wdata, reg_rdata;
	logic [7:0] cpt_data = 8'h00;
	logic [31:0] cmd_pulse;
	logic [4:0] cfg_a, cfg_b, cfg_e, cfg_pp, cfg_ctr;
	logic local_pp_flag, ifc_assert, ren_assert, idle_hold, transceiver_mode_clear;
	int bad_count = 0;
	int compares = 0;

	initial begin
		forever #2.5 mclk = ~mclk;
	end

	aux_host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

	aux_command_decoder u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .cpt_data(cpt_data), .reg_rdata(reg_rdata),
		.cmd_pulse(cmd_pulse), .aux_config_a(cfg_a), .aux_config_b(cfg_b), .aux_config_e(cfg_e),
		.parallel_poll_config(cfg_pp), .internal_counter_config(cfg_ctr), .local_pp_flag(local_pp_flag),
		.ifc_assert(ifc_assert), .ren_assert(ren_assert), .idle_hold(idle_hold),
		.transceiver_mode_clear(transceiver_mode_clear));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cmd(input logic [7:0] d);
		u_host.access(1'b1, CMD_PORT_OFFSET, d);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic run_reset;
		chk({cfg_a, cfg_b, cfg_e, cfg_pp}, 20'h0);
		chk(cfg_ctr, COUNTER_RST);
		chk({local_pp_flag, ifc_assert, ren_assert, transceiver_mode_clear, reg_rdata}, 12'h000);
		chk({idle_hold, cmd_pulse}, {1'b1, 32'h0});
	endtask

	// all 32 codes, descending so releases follow sets and pon comes last
	task automatic run_exec;
		logic eifc, eren;
		eifc = 1'b0;
		eren = 1'b0;
		for (int c = 31; c >= 0; c--) begin
			cmd({3'h0, c[4:0]});
			chk(cmd_pulse, IMPL_MASK[c] ? (ONE << c) : 32'h0);
			chk(transceiver_mode_clear, c == 2);
			chk(idle_hold, c != 0);
			if (c == 31 || c == 23) eren = (c == 31);
			if (c == 30 || c == 22) eifc = (c == 30);
			chk({ifc_assert, ren_assert}, {eifc, eren});
			@(posedge mclk);
			#1;
			chk({cmd_pulse, transceiver_mode_clear}, 33'h0);
		end
		cmd(8'h09);
		chk(local_pp_flag, 1'b1);
		cmd(8'h01);
		chk(local_pp_flag, 1'b0);
	endtask

	task automatic run_hidden;
		cmd({SEL_CONFIG_A, 5'h15});
		cmd({SEL_CONFIG_B, 5'h0a});
		cmd({SEL_CONFIG_E, 5'h1b});
		cmd({SEL_PP_CONFIG, 5'h13});
		cmd({SEL_COUNTER, 5'h03});
		chk(cmd_pulse, 32'h0);
		cmd(8'h5f);
		cmd(8'hff);
		u_host.access(1'b1, 9'h119, {SEL_CONFIG_A, 5'h01});
		chk({cfg_a, cfg_b, cfg_e, cfg_pp, cfg_ctr}, {5'h15, 5'h0a, 5'h1b, 5'h13, 5'h03});
		cmd(8'h09);
		cmd(8'h1f);
		cmd(8'h02);
		chk({cfg_a, cfg_b, cfg_e, cfg_pp, cfg_ctr}, {15'h0, 5'h13, COUNTER_RST});
		chk({idle_hold, local_pp_flag, ren_assert}, 3'b100);
		cmd(8'h00);
		chk(idle_hold, 1'b0);
	endtask

	task automatic run_read;
		@(posedge mclk);
		cpt_data <= 8'h5a;
		u_host.access(1'b0, CMD_PORT_OFFSET, 8'h00);
		chk({reg_rdata, cmd_pulse}, {8'h5a, 32'h0});
		@(posedge mclk);
		#1;
		chk(reg_rdata, 8'h00);
		chk(cfg_pp, 5'h13);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		#1;
		run_reset();
		run_exec();
		run_hidden();
		run_read();
		conclude();
	end

	initial begin
		#20000;
		bad_count++;
		conclude();
	end
endmodule // aux_command_decoder_tb

// ### tb/aux_host_model.sv
module aux_host_model (
	input wire logic mclk, // clock
	output logic [8:0] reg_addr, // register offset
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	output logic [7:0] reg_wdata // write byte
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr = 9'h0e4;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// one strobe cycle, then the bus shows inverted leftovers
	task automatic access(input logic wr, input logic [8:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
	endtask
endmodule // aux_host_model
